// ==== acl_pkg.sv ====
// Shared constants for the rule-table action stage: register map, entry
// word layout, reset values and tick timing.
// Assumes a single 250 MHz core clock and a 32-bit AXI4-Lite register bus.
package acl_pkg;

  localparam int ACL_ENTRIES = 16;
  localparam int ACL_IDX_W = 4;
  localparam int ACL_PORTS = 7;
  localparam int ACL_LIMIT_W = 11;

  // Register byte offsets.
  localparam logic [7:0] ACL_OFS_CTRL = 8'h00;
  localparam logic [7:0] ACL_OFS_ACC_DATA = 8'h04;
  localparam logic [7:0] ACL_OFS_ACC_CTRL = 8'h08;
  localparam logic [7:0] ACL_OFS_INT_STAT = 8'h0c;
  localparam logic [7:0] ACL_OFS_INT_MASK = 8'h10;
  localparam logic [7:0] ACL_OFS_GLB_STAT = 8'h14;
  localparam logic [7:0] ACL_OFS_GLB_MASK = 8'h18;
  localparam logic [7:0] ACL_OFS_EVT_STAT = 8'h1c;

  // Access control fields.
  localparam int ACL_ACC_IDX_LSB = 0;
  localparam int ACL_ACC_WR_BIT = 4;

  // Entry word layout; the low eleven bits double as the tally limit.
  localparam int ACL_F_MAPOP_LSB = 0;
  localparam int ACL_F_RMKVAL_LSB = 2;
  localparam int ACL_F_RMKON_BIT = 5;
  localparam int ACL_F_PRIO_LSB = 6;
  localparam int ACL_F_PMODE_LSB = 9;
  localparam int ACL_F_UNIT_BIT = 11;
  localparam int ACL_F_ALGO_BIT = 12;
  localparam int ACL_F_KIND_LSB = 13;
  localparam int ACL_F_CSEL_LSB = 15;
  localparam int ACL_F_FWD_LSB = 17;

  localparam logic [1:0] ACL_KIND_OFF = 2'h0;
  localparam logic [1:0] ACL_KIND_L2 = 2'h1;
  localparam logic [1:0] ACL_CSEL_COUNT = 2'h0;

  localparam logic [1:0] ACL_PM_QOS = 2'h0;
  localparam logic [1:0] ACL_PM_IF_GT = 2'h1;
  localparam logic [1:0] ACL_PM_IF_LT = 2'h2;
  localparam logic [1:0] ACL_PM_ALWAYS = 2'h3;

  localparam logic [1:0] ACL_MAP_KEEP = 2'h0;
  localparam logic [1:0] ACL_MAP_OR = 2'h1;
  localparam logic [1:0] ACL_MAP_AND = 2'h2;
  localparam logic [1:0] ACL_MAP_REPL = 2'h3;

  localparam logic [31:0] ACL_ENTRY_RST = 32'h0000_0000;
  localparam logic [1:0] ACL_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACL_RESP_SLVERR = 2'h2;

  // Tick timing.
  localparam int ACL_CLK_PERIOD_PS = 4000;
  localparam int ACL_US_PS = 1000000;
  localparam int ACL_CYC_PER_US = ACL_US_PS / ACL_CLK_PERIOD_PS;
  localparam int ACL_US_PER_MS = 1000;

endpackage

// ==== acl_tally.sv ====
// One count-mode tally for a single rule-table entry.
// Assumes one-cycle tick pulses and hit pulses on the same clock.
`timescale 1ns/10ps
`default_nettype none
module acl_tally
  import acl_pkg::*;
(
  input wire logic i_clk_sys, // core clock
  input wire logic i_reset_n, // sync reset, low
  input wire logic i_on, // entry is in count mode
  input wire logic i_algo, // 0 timeout, 1 frame count
  input wire logic i_unit, // 0 us, 1 ms
  input wire logic [ACL_LIMIT_W-1:0] i_limit, // tally limit
  input wire logic i_tick_us, // microsecond pulse
  input wire logic i_tick_ms, // millisecond pulse
  input wire logic i_hit, // matching frame pulse
  output logic o_expire // one-cycle event pulse
);

  typedef struct packed {
    logic armed;
    logic [ACL_LIMIT_W-1:0] cnt;
    logic expire;
  } acl_tally_s;

  acl_tally_s s_q, s_d;
  logic tick;

  assign o_expire = s_q.expire;

  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    tick = i_unit ? i_tick_ms : i_tick_us;
    if (!i_on) begin
      s_d.armed = 1'b0;
      s_d.cnt = '0;
    end else if (!i_algo) begin
      // A fresh frame restarts the window, so it beats a tick.
      if (i_hit) begin
        s_d.armed = 1'b1;
        s_d.cnt = i_limit;
      end else if (s_q.armed && tick) begin
        if (s_q.cnt <= ACL_LIMIT_W'(1)) begin
          s_d.armed = 1'b0;
          s_d.cnt = '0;
          s_d.expire = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - ACL_LIMIT_W'(1);
        end
      end
    end else if (i_hit) begin
      // Ticks are ignored here; the count restarts from zero.
      if (s_q.cnt + ACL_LIMIT_W'(1) == i_limit) begin
        s_d.cnt = '0;
        s_d.expire = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + ACL_LIMIT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ==== acl_action_engine.sv ====
// Rule-table action stage for one switch port, with AXI4-Lite registers.
// Assumes the lookup stage delivers one frame result per valid pulse,
// with the hit entry index already resolved by the matching logic.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module acl_action_engine
  import acl_pkg::*;
#(
  parameter int NPORTS = ACL_PORTS
)(
  input wire logic i_clk_sys, // core clock
  input wire logic i_reset_n, // sync reset, low
  // AXI4-Lite slave.
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [7:0] i_awaddr, // write byte address
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  input wire logic [31:0] i_wdata, // write data
  input wire logic [3:0] i_wstrb, // byte strobes
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  output logic [1:0] o_bresp, // write response
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  input wire logic [7:0] i_araddr, // read byte address
  output logic o_rvalid, // read data valid
  input wire logic i_rready, // read data ready
  output logic [31:0] o_rdata, // read data
  output logic [1:0] o_rresp, // read response
  // Frame result from lookup and classification.
  input wire logic i_frm_valid, // one pulse per frame
  input wire logic i_frm_hit, // an entry matched
  input wire logic [ACL_IDX_W-1:0] i_frm_idx, // matched entry
  input wire logic [2:0] i_frm_qos_prio, // QoS priority
  input wire logic [2:0] i_frm_pcp, // frame PCP bits
  input wire logic [NPORTS-1:0] i_frm_fwd_map, // lookup port map
  // Action result toward forwarding.
  output logic o_act_valid, // result pulse
  output logic [2:0] o_act_prio, // final priority
  output logic [2:0] o_act_pcp, // final PCP bits
  output logic [NPORTS-1:0] o_act_fwd_map, // final port map
  output logic o_port_irq, // port-level interrupt
  output logic o_irq // global interrupt
);

  typedef struct packed {
    logic [ACL_ENTRIES-1:0][31:0] table_q;
    logic enable;
    logic [31:0] acc_data;
    logic [ACL_IDX_W-1:0] acc_idx;
    logic int_stat;
    logic int_mask;
    logic glb_mask;
    logic [ACL_ENTRIES-1:0] evt;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic act_valid;
    logic [2:0] act_prio;
    logic [2:0] act_pcp;
    logic [NPORTS-1:0] act_fwd;
    logic port_irq;
    logic irq;
    logic [7:0] us_div;
    logic [9:0] ms_div;
    logic tick_us;
    logic tick_ms;
  } acl_state_s;

  acl_state_s s_q, s_d;
  logic [ACL_ENTRIES-1:0] expire;
  logic [ACL_ENTRIES-1:0] hit_pulse;
  logic [ACL_ENTRIES-1:0] count_on;

  function automatic logic is_count(input logic [31:0] e);
    return e[ACL_F_KIND_LSB +: 2] == ACL_KIND_L2 &&
           e[ACL_F_CSEL_LSB +: 2] == ACL_CSEL_COUNT;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign o_awready = s_q.awready;
  assign o_wready = s_q.wready;
  assign o_bvalid = s_q.bvalid;
  assign o_bresp = s_q.bresp;
  assign o_arready = s_q.arready;
  assign o_rvalid = s_q.rvalid;
  assign o_rdata = s_q.rdata;
  assign o_rresp = s_q.rresp;
  assign o_act_valid = s_q.act_valid;
  assign o_act_prio = s_q.act_prio;
  assign o_act_pcp = s_q.act_pcp;
  assign o_act_fwd_map = s_q.act_fwd;
  assign o_port_irq = s_q.port_irq;
  assign o_irq = s_q.irq;

  for (genvar g = 0; g < ACL_ENTRIES; g++) begin : g_tally
    assign count_on[g] = s_q.enable && is_count(s_q.table_q[g]);
    assign hit_pulse[g] = i_frm_valid && i_frm_hit && count_on[g] &&
                          i_frm_idx == ACL_IDX_W'(g);
    acl_tally u_tally (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_on(count_on[g]),
      .i_algo(s_q.table_q[g][ACL_F_ALGO_BIT]),
      .i_unit(s_q.table_q[g][ACL_F_UNIT_BIT]),
      .i_limit(s_q.table_q[g][ACL_LIMIT_W-1:0]),
      .i_tick_us(s_q.tick_us),
      .i_tick_ms(s_q.tick_ms),
      .i_hit(hit_pulse[g]),
      .o_expire(expire[g])
    );
  end

  always_comb begin
    logic [31:0] ent;
    logic [31:0] rd;
    logic [1:0] pmode;
    logic [2:0] rprio;
    logic [NPORTS-1:0] mask;
    logic [7:0] wa;
    logic clr_stat;
    logic [ACL_ENTRIES-1:0] clr_evt;
    logic hit_ok;
    ent = s_q.table_q[i_frm_idx];
    rd = '0;
    pmode = ent[ACL_F_PMODE_LSB +: 2];
    rprio = ent[ACL_F_PRIO_LSB +: 3];
    mask = ent[ACL_F_FWD_LSB +: NPORTS];
    wa = s_q.awaddr;
    clr_stat = 1'b0;
    clr_evt = '0;
    hit_ok = 1'b0;
    s_d = s_q;

    // Tick dividers: one-cycle enables for microseconds and milliseconds.
    s_d.tick_us = 1'b0;
    s_d.tick_ms = 1'b0;
    if (s_q.us_div == 8'(ACL_CYC_PER_US - 1)) begin
      s_d.us_div = '0;
      s_d.tick_us = 1'b1;
      if (s_q.ms_div == 10'(ACL_US_PER_MS - 1)) begin
        s_d.ms_div = '0;
        s_d.tick_ms = 1'b1;
      end else begin
        s_d.ms_div = s_q.ms_div + 10'h001;
      end
    end else begin
      s_d.us_div = s_q.us_div + 8'h01;
    end

    // Frame actions; count-mode and disabled entries pass the frame as is.
    // Results hold between frames so forwarding may sample them late.
    hit_ok = i_frm_valid && i_frm_hit && s_q.enable && !is_count(ent) &&
             ent[ACL_F_KIND_LSB +: 2] != ACL_KIND_OFF;
    s_d.act_valid = i_frm_valid;
    if (i_frm_valid) begin
      s_d.act_prio = i_frm_qos_prio;
      s_d.act_pcp = i_frm_pcp;
      s_d.act_fwd = i_frm_fwd_map;
    end
    if (hit_ok) begin
      case (pmode)
        ACL_PM_QOS: s_d.act_prio = i_frm_qos_prio;
        ACL_PM_IF_GT: begin
          if (rprio > i_frm_qos_prio) s_d.act_prio = rprio;
        end
        ACL_PM_IF_LT: begin
          if (rprio < i_frm_qos_prio) s_d.act_prio = rprio;
        end
        default: s_d.act_prio = rprio;
      endcase
      if (ent[ACL_F_RMKON_BIT]) begin
        s_d.act_pcp = ent[ACL_F_RMKVAL_LSB +: 3];
      end
      case (ent[ACL_F_MAPOP_LSB +: 2])
        ACL_MAP_KEEP: s_d.act_fwd = i_frm_fwd_map;
        ACL_MAP_OR: s_d.act_fwd = i_frm_fwd_map | mask;
        ACL_MAP_AND: s_d.act_fwd = i_frm_fwd_map & mask;
        default: s_d.act_fwd = mask;
      endcase
    end

    // Write channel: address and data taken in either order.
    if (s_q.awready && i_awvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = i_awaddr;
    end
    if (s_q.wready && i_wvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = i_wdata;
      s_d.wstrb = i_wstrb;
    end
    if (s_q.bvalid && i_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = ACL_RESP_OKAY;
      case (wa)
        ACL_OFS_CTRL: begin
          if (s_q.wstrb[0]) s_d.enable = s_q.wdata[0];
        end
        ACL_OFS_ACC_DATA: begin
          s_d.acc_data = merge(s_q.acc_data, s_q.wdata, s_q.wstrb);
        end
        ACL_OFS_ACC_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.acc_idx = s_q.wdata[ACL_ACC_IDX_LSB +: ACL_IDX_W];
            if (s_q.wdata[ACL_ACC_WR_BIT]) begin
              s_d.table_q[s_q.wdata[ACL_ACC_IDX_LSB +: ACL_IDX_W]] =
                s_q.acc_data;
            end
          end
        end
        ACL_OFS_INT_STAT: clr_stat = s_q.wstrb[0] && s_q.wdata[0];
        ACL_OFS_INT_MASK: begin
          if (s_q.wstrb[0]) s_d.int_mask = s_q.wdata[0];
        end
        ACL_OFS_GLB_MASK: begin
          if (s_q.wstrb[0]) s_d.glb_mask = s_q.wdata[0];
        end
        ACL_OFS_EVT_STAT: begin
          clr_evt = s_q.wdata[ACL_ENTRIES-1:0] &
                    {{8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
        end
        ACL_OFS_GLB_STAT: s_d.bresp = ACL_RESP_OKAY;
        default: s_d.bresp = ACL_RESP_SLVERR;
      endcase
    end

    // Only tally expiries feed status; a new event beats a same-cycle clear.
    s_d.evt = (s_q.evt & ~clr_evt) | expire;
    s_d.int_stat = (s_q.int_stat && !clr_stat) || (|expire);
    s_d.port_irq = s_d.int_stat && s_d.int_mask;
    s_d.irq = s_d.port_irq && s_d.glb_mask;

    // Read channel.
    if (s_q.rvalid && i_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && i_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = ACL_RESP_OKAY;
      case (i_araddr)
        ACL_OFS_CTRL: rd[0] = s_q.enable;
        ACL_OFS_ACC_DATA: rd = s_q.table_q[s_q.acc_idx];
        ACL_OFS_ACC_CTRL: rd[ACL_ACC_IDX_LSB +: ACL_IDX_W] = s_q.acc_idx;
        ACL_OFS_INT_STAT: rd[0] = s_q.int_stat;
        ACL_OFS_INT_MASK: rd[0] = s_q.int_mask;
        ACL_OFS_GLB_STAT: rd[0] = s_q.port_irq;
        ACL_OFS_GLB_MASK: rd[0] = s_q.glb_mask;
        ACL_OFS_EVT_STAT: rd[ACL_ENTRIES-1:0] = s_q.evt;
        default: s_d.rresp = ACL_RESP_SLVERR;
      endcase
      s_d.rdata = rd;
    end

    // Ready flags are registered so the bus sees flop outputs only.
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      s_q <= '0;
      for (int i = 0; i < ACL_ENTRIES; i++) begin
        s_q.table_q[i] <= ACL_ENTRY_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ==== acl_ae_properties.sv ====
// Port-level properties of the rule-table action stage.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module acl_ae_checker
  import acl_pkg::*;
#(
  parameter int NPORTS = ACL_PORTS
)(
  input wire logic i_clk_sys, // core clock
  input wire logic i_reset_n, // sync reset, low
  input wire logic i_frm_valid, // frame pulse
  input wire logic i_frm_hit, // entry matched
  input wire logic [2:0] i_frm_qos_prio, // QoS priority
  input wire logic [2:0] i_frm_pcp, // frame PCP
  input wire logic [NPORTS-1:0] i_frm_fwd_map, // lookup map
  input wire logic o_act_valid, // result pulse
  input wire logic [2:0] o_act_prio, // final priority
  input wire logic [2:0] o_act_pcp, // final PCP
  input wire logic [NPORTS-1:0] o_act_fwd_map, // final map
  input wire logic o_port_irq, // port interrupt
  input wire logic o_irq, // global interrupt
  input wire logic o_awready, // write address ready
  input wire logic o_wready, // write data ready
  input wire logic o_bvalid, // write response valid
  input wire logic i_arvalid, // read address valid
  input wire logic o_arready, // read address ready
  input wire logic o_rvalid // read data valid
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  AST_ACT_LAT: assert property (i_frm_valid |=> o_act_valid)
    else $error("result missing after frame");
  AST_ACT_PULSE: assert property (!i_frm_valid |=> !o_act_valid)
    else $error("result without frame");
  AST_PASS: assert property (i_frm_valid && !i_frm_hit |=>
    o_act_prio == $past(i_frm_qos_prio) && o_act_pcp == $past(i_frm_pcp)
    && o_act_fwd_map == $past(i_frm_fwd_map))
    else $error("unmatched frame altered");
  AST_HOLD: assert property (!o_act_valid |-> $stable(o_act_prio) &&
    $stable(o_act_pcp) && $stable(o_act_fwd_map))
    else $error("result changed between frames");
  AST_IRQ_GLB: assert property (o_irq |-> o_port_irq || $past(o_port_irq))
    else $error("global interrupt without port interrupt");
  AST_B_BUSY: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write slot free during response");
  AST_R_BUSY: assert property (o_rvalid |-> !o_arready)
    else $error("read slot free during response");
  AST_RD_LAT: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
endmodule
bind acl_action_engine acl_ae_checker #(.NPORTS(NPORTS)) u_chk (
  .i_clk_sys, .i_reset_n, .i_frm_valid, .i_frm_hit, .i_frm_qos_prio,
  .i_frm_pcp, .i_frm_fwd_map, .o_act_valid, .o_act_prio, .o_act_pcp,
  .o_act_fwd_map, .o_port_irq, .o_irq, .o_awready, .o_wready, .o_bvalid,
  .i_arvalid, .o_arready, .o_rvalid
);
`default_nettype wire

// ==== acl_lkp_model.sv ====
// Model of the lookup stage that hands frame results to the action stage.
// Assumes the caller enters send just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module acl_lkp_model
  import acl_pkg::*;
#(
  parameter int NPORTS = ACL_PORTS
)(
  input wire logic i_clk_sys, // core clock
  output logic o_frm_valid, // frame pulse
  output logic o_frm_hit, // entry matched
  output logic [3:0] o_frm_idx, // matched entry
  output logic [2:0] o_frm_qos_prio, // QoS priority
  output logic [2:0] o_frm_pcp, // frame PCP
  output logic [NPORTS-1:0] o_frm_fwd_map // lookup map
);
  initial begin
    o_frm_valid = 1'b0;
    {o_frm_hit, o_frm_idx, o_frm_qos_prio, o_frm_pcp, o_frm_fwd_map} = '0;
  end
  // Fields are inverted once the pulse ends, so stale values never help.
  task automatic send(input logic h, input logic [3:0] x,
                      input logic [2:0] q, input logic [2:0] c,
                      input logic [NPORTS-1:0] m);
    @(posedge i_clk_sys);
    o_frm_valid <= 1'b1;
    {o_frm_hit, o_frm_idx, o_frm_qos_prio, o_frm_pcp, o_frm_fwd_map}
      <= {h, x, q, c, m};
    @(posedge i_clk_sys);
    o_frm_valid <= 1'b0;
    {o_frm_hit, o_frm_idx, o_frm_qos_prio, o_frm_pcp, o_frm_fwd_map}
      <= ~{h, x, q, c, m};
  endtask
endmodule
`default_nettype wire

// ==== test_acl_action_count_engine.sv ====
// Self-checking bench for the rule-table action stage.
// Assumes the 250 MHz clock and the register map of acl_pkg.
`timescale 1ns/10ps
`default_nettype none
module test_acl_action_count_engine;
  import acl_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hf;
  wire logic i_frm_valid, i_frm_hit;
  wire logic [3:0] i_frm_idx;
  wire logic [2:0] i_frm_qos_prio, i_frm_pcp;
  wire logic [6:0] i_frm_fwd_map;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_act_valid, o_port_irq, o_irq;
  logic [1:0] o_bresp, o_rresp, rr;
  logic [31:0] o_rdata, rv;
  logic [2:0] o_act_prio, o_act_pcp;
  logic [6:0] o_act_fwd_map;
  int error_cnt = 0, samples_checked = 0, cyc = 0;

  acl_action_engine uut (.*);
  acl_lkp_model u_lkp (.i_clk_sys(i_clk_sys), .o_frm_valid(i_frm_valid),
    .o_frm_hit(i_frm_hit), .o_frm_idx(i_frm_idx),
    .o_frm_qos_prio(i_frm_qos_prio), .o_frm_pcp(i_frm_pcp),
    .o_frm_fwd_map(i_frm_fwd_map));

  always #2 i_clk_sys = ~i_clk_sys;

  task final_report();
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    rr = o_bresp;
    i_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    rv = o_rdata;
    rr = o_rresp;
    i_rready <= 1'b0;
  endtask

  task ld(input logic [3:0] x, input logic [31:0] w);
    wr(ACL_OFS_ACC_DATA, w);
    wr(ACL_OFS_ACC_CTRL, {27'h0, 1'b1, x});
  endtask

  task fr(input logic [3:0] x, input logic [2:0] q, ep, ec,
          input logic [6:0] em);
    u_lkp.send(1'b1, x, q, 3'h1, 7'h4c);
    #1;
    chk(o_act_valid, 1);
    chk(o_act_prio, ep);
    chk(o_act_pcp, ec);
    chk(o_act_fwd_map, em);
  endtask

  function automatic logic [31:0] ent(input logic [1:0] k, cs,
    input logic al, u, input logic [10:0] lim, input logic [6:0] m);
    return {8'h00, m, cs, k, al, u, lim};
  endfunction

  function automatic logic [2:0] ep(input int pm, input logic [2:0] p, q);
    case (pm)
      0: return q;
      1: return p > q ? p : q;
      2: return p < q ? p : q;
      default: return p;
    endcase
  endfunction

  function automatic logic [6:0] em(input int mm, input logic [6:0] l, m);
    case (mm)
      0: return l;
      1: return l | m;
      2: return l & m;
      default: return m;
    endcase
  endfunction

  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(ACL_OFS_CTRL);
    chk(rv, 0);
    rd(8'h20);
    chk(rr, ACL_RESP_SLVERR);
    wr(8'h20, 1);
    chk(rr, ACL_RESP_SLVERR);
    wr(ACL_OFS_CTRL, 1);
    chk(rr, ACL_RESP_OKAY);
    wr(ACL_OFS_GLB_MASK, 1);
    ld(2, ent(ACL_KIND_OFF, 2'h3, 0, 0, 11'h7ff, 7'h00));
    fr(2, 3'h1, 3'h1, 3'h1, 7'h4c);
    for (int k = 0; k < 4; k++) begin
      ld(1, ent(ACL_KIND_L2, 2'h3, 0, 0,
                {k[1:0], 3'h4, k[0], 3'h5, k[1:0]}, 7'h35));
      rd(ACL_OFS_ACC_DATA);
      chk(rv[10:0], {k[1:0], 3'h4, k[0], 3'h5, k[1:0]});
      for (int q = 2; q < 8; q += 4)
        fr(1, q[2:0], ep(k, 3'h4, q[2:0]), k[0] ? 3'h5 : 3'h1,
           em(k, 7'h4c, 7'h35));
    end
    u_lkp.send(1'b0, 4'h1, 3'h3, 3'h6, 7'h11);
    #1;
    chk(o_act_prio, 3);
    chk({o_act_pcp, o_act_fwd_map}, {3'h6, 7'h11});
    @(posedge i_clk_sys);
    #1;
    chk({o_act_valid, o_act_prio}, {1'b0, 3'h3});
    rd(ACL_OFS_INT_STAT);
    chk(rv, 0);
    wr(ACL_OFS_INT_MASK, 1);
    ld(3, ent(ACL_KIND_L2, ACL_CSEL_COUNT, 1, 0, 11'd3, 7'h7f));
    repeat (2) fr(3, 3'h2, 3'h2, 3'h1, 7'h4c);
    repeat (4) @(posedge i_clk_sys);
    chk(o_port_irq, 0);
    fr(3, 3'h2, 3'h2, 3'h1, 7'h4c);
    repeat (4) @(posedge i_clk_sys);
    chk(o_port_irq, 1);
    chk(o_irq, 1);
    rd(ACL_OFS_EVT_STAT);
    chk(rv, 32'h8);
    rd(ACL_OFS_INT_STAT);
    chk(rv, 1);
    wr(ACL_OFS_INT_STAT, 1);
    wr(ACL_OFS_EVT_STAT, 32'hffff);
    repeat (3) @(posedge i_clk_sys);
    chk(o_port_irq, 0);
    wr(ACL_OFS_INT_MASK, 0);
    ld(5, ent(ACL_KIND_L2, ACL_CSEL_COUNT, 0, 1, 11'd1, 7'h00));
    fr(5, 3'h2, 3'h2, 3'h1, 7'h4c);
    ld(4, ent(ACL_KIND_L2, ACL_CSEL_COUNT, 0, 0, 11'd2, 7'h00));
    fr(4, 3'h2, 3'h2, 3'h1, 7'h4c);
    repeat (230) @(posedge i_clk_sys);
    rd(ACL_OFS_INT_STAT);
    chk(rv, 0);
    repeat (280) @(posedge i_clk_sys);
    rd(ACL_OFS_INT_STAT);
    chk(rv, 1);
    rd(ACL_OFS_EVT_STAT);
    chk(rv, 32'h10);
    chk(o_port_irq, 0);
    wr(ACL_OFS_INT_MASK, 1);
    repeat (3) @(posedge i_clk_sys);
    chk(o_port_irq, 1);
    chk(o_irq, 1);
    wr(ACL_OFS_GLB_MASK, 0);
    repeat (3) @(posedge i_clk_sys);
    chk(o_irq, 0);
    final_report();
  end
endmodule
`default_nettype wire
